/* File: dsit_map.svh */
// Constants for the data-space decode and interrupt timing block.
// Assumes inclusion by its bare name from every design file that needs them.
`ifndef DSIT_MAP_SVH
`define DSIT_MAP_SVH

// Data-space region limits (first address past each region)
`define DSIT_REGF_END 16'h0020
`define DSIT_STDIO_END 16'h0060
`define DSIT_EXTIO_END 16'h0200
`define DSIT_ISRAM_END 16'h2200
// Short in/out instructions start at the standard I/O base
`define DSIT_IO_BASE 16'h0020
// First register-file address of the X/Y/Z pointer bytes
`define DSIT_PTR_BASE 16'h001A
`define DSIT_PTR_BYTES 6

// Register offsets on the control port
`define DSIT_XMC_OFS 8'h00
`define DSIT_SFR_OFS 8'h01
`define DSIT_STAT_OFS 8'h02
// Field positions
`define DSIT_SRE_BIT 7
`define DSIT_WS_MSB 1
`define DSIT_WS_LSB 0
`define DSIT_GIE_BIT 7
// Reset values
`define DSIT_XMC_RST 8'h00
`define DSIT_SFR_RST 8'h00
`define DSIT_PC_RST 0

// Timing counts in core clock cycles
`define DSIT_IRQ_ENTRY_CYC 5'h05
`define DSIT_VEC_JMP_CYC 5'h03
`define DSIT_SLEEP_EXTRA_CYC 5'h05
`define DSIT_RETURN_FROM_IRQ_INSTR_CYC 5'h05
`define DSIT_STK_EXT_CYC 5'h03
`define DSIT_STK_WS_MUL 5'h02
`define DSIT_EXT_ACC_CYC 5'h01
// Interrupt vectors sit two program words apart
`define DSIT_VEC_SHIFT 1

`endif

/* File: dsit_pkg.sv */
// Types shared by the data-space decode and interrupt timing block.
// Assumes compilation before any design module that imports it.
package dsit_pkg;

    // Instruction classes reported by the core decoder
    typedef enum logic [3:0] {
        OP_ALU, OP_SEI, OP_CLI, OP_RETURN_FROM_IRQ_INSTR, OP_CALL, OP_RET, OP_LD,
        OP_ST, OP_PUSH, OP_POP, OP_IN, OP_OUT, OP_SLEEP
    } dsit_op_t;

    // Data-space regions
    typedef enum logic [2:0] {
        RG_REGF, RG_STDIO, RG_EXTIO, RG_ISRAM, RG_EXT, RG_NONE
    } dsit_region_t;

    // Pointer select and addressing mode of loads and stores
    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z, PTR_DIRECT} dsit_ptr_t;
    typedef enum logic [1:0] {AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_DISP} dsit_mode_t;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_IRQ = 5'b00010,
        ST_JMP = 5'b00100,
        ST_SLEEP = 5'b01000,
        ST_WAKE = 5'b10000
    } dsit_state_t;

endpackage

/* File: dsit_region_dec.sv */
// Data-space address decoder: splits a 16-bit address into its region.
// Assumes the external enable comes from the control register on the same clock.
`timescale 1ns/1ps
`include "dsit_map.svh"

module dsit_region_dec
    import dsit_pkg::*;
(
    input wire logic [15:0] addr,
    input wire logic ext_en,
    output dsit_region_t region
);

    // Regions follow each other upward; above internal SRAM only when enabled
    always_comb begin
        if (addr < `DSIT_REGF_END) begin
            region = RG_REGF;
        end else if (addr < `DSIT_STDIO_END) begin
            region = RG_STDIO;
        end else if (addr < `DSIT_EXTIO_END) begin
            region = RG_EXTIO;
        end else if (addr < `DSIT_ISRAM_END) begin
            region = RG_ISRAM;
        end else if (ext_en) begin
            region = RG_EXT;
        end else begin
            region = RG_NONE;
        end
    end

endmodule

/* File: dsit_core_timing.sv */
// Core sequencer: interrupt entry/return timing, data-space access timing,
// pointer registers and external SRAM strobes.
// Assumes decoder, interrupt controller and stack pointer share core_clk.
//
// Function
// - After enabling interrupts, one more instruction runs before any pending one.
// - Interrupt entry lasts at least five cycles, then execution resumes at the vector.
// - The vector jump takes three cycles before the handler starts.
// - A multi-cycle instruction completes before interrupt entry begins.
// - Waking from sleep adds five cycles on top of the start-up time.
// - Interrupt return takes five cycles, pops three bytes, sets global enable.
// - Program counter is 15, 16 or 17 bits and counts 16-bit words.
// - Extended I/O from 0x060 is reachable only by loads and stores.
// - Decode: 32 register file, 64 I/O, 416 extended I/O, 8192 SRAM.
// - Enabled external memory fills the 64K space above internal SRAM.
// - Addresses above internal memory go to external SRAM with same instructions.
// - External strobes stay inactive throughout any internal access.
// - External SRAM works only when the enable bit is set.
// - Each external byte without wait states costs one extra cycle.
// - External stack adds three cycles to entry, calls and returns.
// - One to three wait states add two to four cycles per byte.
// - External stack with wait states adds five, seven or nine cycles.
// - Displacement up to 63 is added to the Y or Z pointer.
// - Registers 26 to 31 are X, Y, Z; pre-decrement and post-increment update them.
// - Direct addressing reaches the whole data space.
// - Interrupt entry clears the global interrupt enable.
// - After interrupt return one instruction runs before a pending interrupt.
// - Disabling interrupts acts at once; a same-cycle request is taken first, except in the one-instruction shadow.
`timescale 1ns/1ps
`include "dsit_map.svh"

module dsit_core_timing
    import dsit_pkg::*;
#(
    parameter int PC_W = 17,
    parameter int WAKE_CYC = 4,
    parameter int VEC_W = 6
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic op_valid,
    input dsit_op_t op_code,
    input wire logic [2:0] op_cycles,
    input wire logic op_words,
    input dsit_ptr_t op_ptr,
    input dsit_mode_t op_mode,
    input wire logic [5:0] op_disp,
    input wire logic [15:0] op_direct,
    input wire logic [5:0] op_io,
    input wire logic [7:0] op_wdata,
    output logic op_ready,
    input wire logic irq_req,
    input wire logic [VEC_W-1:0] irq_vec,
    output logic irq_ack,
    input wire logic [15:0] sp_addr,
    output logic sp_push3,
    output logic sp_pop3,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_target,
    output logic [PC_W-1:0] program_counter,
    output logic gie,
    output dsit_region_t acc_region,
    output logic [7:0] rd_data,
    output logic [15:0] ext_addr,
    input wire logic [7:0] ext_data_in,
    output logic [7:0] ext_data_out,
    output logic ext_data_oe,
    output logic ext_write_strobe_pin_n,
    output logic ext_read_strobe_pin_n
);

    dsit_state_t state;
    logic [7:0] busy_cnt;
    logic defer;
    logic from_sleep;
    logic [7:0] ext_mem_control_register;
    logic [7:0] status_flags_register;
    logic [7:0] ptr_b [`DSIT_PTR_BYTES];
    logic [2:0] ext_cnt;
    logic ext_is_rd;
    logic [7:0] ext_sync1;
    logic [7:0] ext_sync2;
    logic ext_mem_enable_bit;
    logic [4:0] ws;
    logic accept;
    logic take_irq;
    logic is_mem;
    logic is_rd;
    logic is_short;
    logic stack_op;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic [15:0] acc_addr;
    logic [15:0] ptr_off;
    dsit_region_t acc_rg;
    dsit_region_t stk_rg;
    logic data_ext;
    logic stk_ext;
    logic [4:0] stk_extra;
    logic [4:0] op_total;
    logic [4:0] irq_total;

    // Control fields
    assign ext_mem_enable_bit = ext_mem_control_register[`DSIT_SRE_BIT];
    assign ws = {3'b000, ext_mem_control_register[`DSIT_WS_MSB:`DSIT_WS_LSB]};
    assign gie = status_flags_register[`DSIT_GIE_BIT];

    // Interrupt is taken only at an instruction boundary, never while deferred
    assign take_irq = (state == ST_RUN) && (busy_cnt == 8'h00) && irq_req && gie && !defer;
    assign irq_ack = take_irq && clk_en;
    assign op_ready = (state == ST_RUN) && (busy_cnt == 8'h00) && !take_irq && clk_en;
    assign accept = op_valid && op_ready;

    // Pointer selection and effective data address
    always_comb begin
        is_short = (op_code == OP_IN) || (op_code == OP_OUT);
        is_mem = (op_code == OP_LD) || (op_code == OP_ST) || (op_code == OP_PUSH) || (op_code == OP_POP) || is_short;
        is_rd = (op_code == OP_LD) || (op_code == OP_POP) || (op_code == OP_IN);
        stack_op = (op_code == OP_CALL) || (op_code == OP_RET) || (op_code == OP_RETURN_FROM_IRQ_INSTR);
        case (op_ptr)
            PTR_X: ptr_val = {ptr_b[1], ptr_b[0]};
            PTR_Y: ptr_val = {ptr_b[3], ptr_b[2]};
            PTR_Z: ptr_val = {ptr_b[5], ptr_b[4]};
            default: ptr_val = 16'h0000;
        endcase
        ptr_new = ptr_val;
        acc_addr = ptr_val;
        ptr_off = {10'h000, op_disp};
        if (op_code == OP_PUSH || op_code == OP_POP) begin
            acc_addr = sp_addr;
        end else if (is_short) begin
            acc_addr = `DSIT_IO_BASE + {10'h000, op_io};
        end else if (op_ptr == PTR_DIRECT) begin
            acc_addr = op_direct;
        end else begin
            case (op_mode)
                AM_POSTINC: ptr_new = ptr_val + 16'h0001;
                AM_PREDEC: begin
                    ptr_new = ptr_val - 16'h0001;
                    acc_addr = ptr_new;
                end
                AM_DISP: begin
                    if (op_ptr != PTR_X) begin
                        acc_addr = ptr_val + ptr_off;
                    end
                end
                default: acc_addr = ptr_val;
            endcase
        end
    end

    // Region decode of the data access and of the stack
    dsit_region_dec u_acc_dec (
        .addr(acc_addr),
        .ext_en(ext_mem_enable_bit),
        .region(acc_rg)
    );
    dsit_region_dec u_stk_dec (
        .addr(sp_addr),
        .ext_en(ext_mem_enable_bit),
        .region(stk_rg)
    );

    // Cycle cost of the accepted instruction and of interrupt entry
    always_comb begin
        data_ext = is_mem && !is_short && (acc_rg == RG_EXT);
        stk_ext = (stk_rg == RG_EXT);
        stk_extra = stk_ext ? 5'(`DSIT_STK_EXT_CYC + `DSIT_STK_WS_MUL * ws) : 5'h00;
        op_total = (op_code == OP_RETURN_FROM_IRQ_INSTR) ? `DSIT_RETURN_FROM_IRQ_INSTR_CYC : {2'b00, op_cycles};
        if (data_ext) begin
            op_total = 5'(op_total + `DSIT_EXT_ACC_CYC + ws);
        end
        if (stack_op) begin
            op_total = 5'(op_total + stk_extra);
        end
        if (op_total == 5'h00) begin
            op_total = 5'h01;
        end
        irq_total = 5'(`DSIT_IRQ_ENTRY_CYC + stk_extra);
        if (from_sleep) begin
            irq_total = 5'(irq_total + `DSIT_SLEEP_EXTRA_CYC);
        end
    end

    // Sequencer: run, entry, vector jump, sleep and wake-up
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_RUN;
            busy_cnt <= 8'h00;
        end else if (clk_en) begin
            case (state)
                ST_RUN: begin
                    if (take_irq) begin
                        state <= ST_IRQ;
                        busy_cnt <= {3'b000, 5'(irq_total - 5'h01)};
                    end else if (accept && op_code == OP_SLEEP) begin
                        state <= ST_SLEEP;
                    end else if (accept) begin
                        busy_cnt <= {3'b000, 5'(op_total - 5'h01)};
                    end else if (busy_cnt != 8'h00) begin
                        busy_cnt <= busy_cnt - 8'h01;
                    end
                end
                ST_IRQ: begin
                    if (busy_cnt == 8'h00) begin
                        state <= ST_JMP;
                        busy_cnt <= {3'b000, 5'(`DSIT_VEC_JMP_CYC - 5'h01)};
                    end else begin
                        busy_cnt <= busy_cnt - 8'h01;
                    end
                end
                ST_JMP: begin
                    if (busy_cnt == 8'h00) begin
                        state <= ST_RUN;
                    end else begin
                        busy_cnt <= busy_cnt - 8'h01;
                    end
                end
                ST_SLEEP: begin
                    if (irq_req) begin
                        state <= ST_WAKE;
                        busy_cnt <= 8'(WAKE_CYC - 1);
                    end
                end
                ST_WAKE: begin
                    if (busy_cnt == 8'h00) begin
                        state <= ST_RUN;
                    end else begin
                        busy_cnt <= busy_cnt - 8'h01;
                    end
                end
                default: begin
                    state <= ST_RUN;
                    busy_cnt <= 8'h00;
                end
            endcase
        end
    end

    // Remembers a wake-up until the entry that it lengthens starts
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            from_sleep <= 1'b0;
        end else if (clk_en) begin
            if (state == ST_SLEEP && irq_req) begin
                from_sleep <= 1'b1;
            end else if (take_irq || accept) begin
                from_sleep <= 1'b0;
            end
        end
    end

    // One-instruction shadow after enabling interrupts or returning
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            defer <= 1'b0;
        end else if (clk_en) begin
            if (accept && (op_code == OP_SEI || op_code == OP_RETURN_FROM_IRQ_INSTR)) begin
                defer <= 1'b1;
            end else if (reg_wr && reg_addr == `DSIT_SFR_OFS && reg_wdata[`DSIT_GIE_BIT] && !gie) begin
                defer <= 1'b1;
            end else if (accept) begin
                defer <= 1'b0;
            end
        end
    end

    // Status flags: bus write, then instruction effects, entry clear last
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_flags_register <= `DSIT_SFR_RST;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `DSIT_SFR_OFS) begin
                status_flags_register <= reg_wdata;
            end
            if (accept && (op_code == OP_SEI || op_code == OP_RETURN_FROM_IRQ_INSTR)) begin
                status_flags_register[`DSIT_GIE_BIT] <= 1'b1;
            end
            if (accept && op_code == OP_CLI) begin
                status_flags_register[`DSIT_GIE_BIT] <= 1'b0;
            end
            if (take_irq) begin
                status_flags_register[`DSIT_GIE_BIT] <= 1'b0;
            end
        end
    end

    // External memory control: enable bit and wait-state field
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_mem_control_register <= `DSIT_XMC_RST;
        end else if (clk_en && reg_wr && reg_addr == `DSIT_XMC_OFS) begin
            ext_mem_control_register <= reg_wdata;
        end
    end

    // Register read port, data valid one cycle after the strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `DSIT_XMC_OFS: reg_rdata <= ext_mem_control_register;
                    `DSIT_SFR_OFS: reg_rdata <= status_flags_register;
                    `DSIT_STAT_OFS: reg_rdata <= {defer, busy_cnt != 8'h00, state, ext_cnt != 3'h0};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Pointer bytes: auto-update and direct stores to addresses 26..31
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `DSIT_PTR_BYTES; i++) begin
                ptr_b[i] <= 8'h00;
            end
        end else if (clk_en && accept) begin
            if ((op_code == OP_LD || op_code == OP_ST) && op_ptr != PTR_DIRECT &&
                (op_mode == AM_POSTINC || op_mode == AM_PREDEC)) begin
                ptr_b[{op_ptr, 1'b0}] <= ptr_new[7:0];
                ptr_b[{op_ptr, 1'b1}] <= ptr_new[15:8];
            end
            if (op_code == OP_ST && acc_addr >= `DSIT_PTR_BASE && acc_addr < `DSIT_REGF_END) begin
                ptr_b[3'(acc_addr - `DSIT_PTR_BASE)] <= op_wdata;
            end
        end
    end

    // Program counter in words: advance, load, or vector on entry
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            program_counter <= PC_W'(`DSIT_PC_RST);
        end else if (clk_en) begin
            if (accept) begin
                program_counter <= program_counter + PC_W'(1) + PC_W'(op_words);
            end
            if (pc_load) begin
                program_counter <= pc_target;
            end
            if (take_irq) begin
                program_counter <= PC_W'(irq_vec) << `DSIT_VEC_SHIFT;
            end
        end
    end

    // Three-byte stack moves for entry, calls and returns
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sp_push3 <= 1'b0;
            sp_pop3 <= 1'b0;
        end else if (clk_en) begin
            sp_push3 <= take_irq || (accept && op_code == OP_CALL);
            sp_pop3 <= accept && (op_code == OP_RET || op_code == OP_RETURN_FROM_IRQ_INSTR);
        end
    end

    // External access window and strobes, stretched by sampled wait states
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_cnt <= 3'h0;
            ext_is_rd <= 1'b0;
            ext_addr <= 16'h0000;
            ext_data_out <= 8'h00;
            ext_data_oe <= 1'b0;
            ext_write_strobe_pin_n <= 1'b1;
            ext_read_strobe_pin_n <= 1'b1;
        end else if (clk_en) begin
            if (accept && data_ext) begin
                ext_cnt <= 3'(`DSIT_EXT_ACC_CYC + ws);
                ext_is_rd <= is_rd;
                ext_addr <= acc_addr;
                ext_data_out <= op_wdata;
                ext_data_oe <= !is_rd;
                ext_write_strobe_pin_n <= is_rd;
                ext_read_strobe_pin_n <= !is_rd;
            end else if (ext_cnt != 3'h0) begin
                ext_cnt <= ext_cnt - 3'h1;
                if (ext_cnt == 3'h1) begin
                    ext_data_oe <= 1'b0;
                    ext_write_strobe_pin_n <= 1'b1;
                    ext_read_strobe_pin_n <= 1'b1;
                end
            end
        end
    end

    // Read data pins pass two flip-flops before use
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_sync1 <= 8'h00;
            ext_sync2 <= 8'h00;
        end else if (clk_en) begin
            ext_sync1 <= ext_data_in;
            ext_sync2 <= ext_sync1;
        end
    end

    // Load result and region of the last access
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 8'h00;
            acc_region <= RG_NONE;
        end else if (clk_en) begin
            if (accept && is_mem) begin
                acc_region <= acc_rg;
                if (is_rd && acc_addr >= `DSIT_PTR_BASE && acc_addr < `DSIT_REGF_END) begin
                    rd_data <= ptr_b[3'(acc_addr - `DSIT_PTR_BASE)];
                end
            end else if (ext_cnt == 3'h1 && ext_is_rd) begin
                rd_data <= ext_sync2;
            end
        end
    end

    a_sei_defer: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        (accept && op_code == OP_SEI) |=> !irq_ack)
        else $error("interrupt taken right after enable");
    a_entry_len: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        irq_ack |=> (state == ST_IRQ) [*5])
        else $error("entry shorter than five cycles");
    a_vec_jump: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        $rose(state == ST_JMP) |-> (state == ST_JMP) [*3] ##1 (state == ST_RUN))
        else $error("vector jump not three cycles");
    a_multi_done: assert property (
        @(posedge core_clk) disable iff (!nrst)
        irq_ack |-> busy_cnt == 8'h00 && $past(busy_cnt) <= 8'h01)
        else $error("entry began inside an instruction");
    a_wake_extra: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        (irq_ack && from_sleep) |=> (state == ST_IRQ) [*8])
        else $error("wake entry not lengthened");
    a_return_from_irq_instr_len: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        (accept && op_code == OP_RETURN_FROM_IRQ_INSTR && !stk_ext) |=> gie && sp_pop3 && !op_ready ##1 !op_ready [*3] ##1 op_ready)
        else $error("return not five cycles");
    a_short_io: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (accept && is_short) |-> acc_addr < `DSIT_STDIO_END)
        else $error("short io reached extended io");
    a_int_strobe: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        (accept && is_mem && acc_rg != RG_EXT && ext_cnt <= 3'h1) |=>
        ext_read_strobe_pin_n && ext_write_strobe_pin_n)
        else $error("strobe active on internal access");
    a_ws_two: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        (accept && data_ext && is_rd && ws == 5'h02) |=> !ext_read_strobe_pin_n [*3] ##1 ext_read_strobe_pin_n)
        else $error("two wait states not three cycles");
    a_cli_now: assert property (
        @(posedge core_clk) disable iff (!nrst || !clk_en)
        (accept && op_code == OP_CLI) |=> !gie && !irq_ack)
        else $error("interrupt after disable");

endmodule

/* File: dsit_sram_model.sv */
// External SRAM stand-in on the core's memory bus.
// Assumes address and read strobe come from the core on core_clk.
`timescale 1ns/1ps
module dsit_sram_model (
    input wire logic core_clk,
    input wire logic [15:0] ext_addr,
    input wire logic ext_read_strobe_pin_n,
    output logic [7:0] ext_data_in
);
    logic [7:0] last = 8'h00;
    // Remember the bus so a released bus can toggle
    always_ff @(posedge core_clk) last <= ext_data_in;
    // Answer at once while selected, otherwise a changing pattern
    assign ext_data_in = !ext_read_strobe_pin_n ? ext_addr[7:0] ^ 8'h5a : ~last;
endmodule

/* File: dsit_core_timing_bench.sv */
// Self-checking bench for the core sequencer with an SRAM model.
// Assumes the design's default parameters.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("Error %0t: got %h want %h", $time, a, b); end end
module dsit_core_timing_bench;
    import dsit_pkg::*;
    logic core_clk = 0, nrst = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, op_valid = 0, op_words = 0, irq_req = 0, pc_load = 0;
    logic [7:0] reg_addr = '0, reg_wdata = '0, op_wdata = '0, reg_rdata, rd_data, ext_data_in, ext_data_out;
    logic [2:0] op_cycles = '0;
    logic [5:0] op_disp = '0, op_io = '0, irq_vec = 6'h05;
    logic [15:0] op_direct = '0, sp_addr = 16'h21ff, ext_addr;
    logic [16:0] pc_target = '0, program_counter;
    dsit_op_t op_code = OP_ALU;
    dsit_ptr_t op_ptr = PTR_DIRECT;
    dsit_mode_t op_mode = AM_PLAIN;
    dsit_region_t acc_region;
    logic op_ready, irq_ack, sp_push3, sp_pop3, gie, ext_data_oe, ext_write_strobe_pin_n, ext_read_strobe_pin_n;
    int n_fail = 0, comparisons = 0, n, lo;
    dsit_core_timing u_dut (.*);
    dsit_sram_model u_sram (.*);
    // Core clock, 4 ns period
    always #2 core_clk = ~core_clk;
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Offer one instruction, count stall cycles, strobe-low and stack-pop cycles
    task automatic op(input dsit_op_t c, input logic [15:0] a, input int total, strobes, input dsit_region_t rg);
        @(posedge core_clk) begin
            op_valid <= 1'b1;
            op_code <= c;
            op_cycles <= 3'h2;
            op_direct <= a;
            op_io <= a[5:0];
            op_wdata <= 8'hc3 ^ a[15:8];
        end
        do @(negedge core_clk); while (op_ready !== 1'b1);
        @(posedge core_clk) op_valid <= 1'b0;
        n = 0;
        lo = 0;
        do begin
            @(negedge core_clk);
            n++;
            lo += !(ext_read_strobe_pin_n & ext_write_strobe_pin_n) + sp_pop3;
            `CHK(ext_data_oe, !ext_write_strobe_pin_n)
        end while (op_ready !== 1'b1 && n < 40);
        `CHK(n, total)
        `CHK(lo, strobes)
        `CHK(acc_region, rg)
    endtask
    task automatic t_decode;
        op(OP_LD, 16'h001f, 2, 0, RG_REGF);
        op(OP_LD, 16'h005f, 2, 0, RG_STDIO);
        op(OP_ST, 16'h0060, 2, 0, RG_EXTIO);
        op(OP_OUT, 16'h003f, 2, 0, RG_STDIO);
        op(OP_LD, 16'h21ff, 2, 0, RG_ISRAM);
        op(OP_LD, 16'h2200, 2, 0, RG_NONE);
    endtask
    task automatic t_regs;
        logic [7:0] d;
        rd(8'h00, d);
        `CHK(d, 8'h00)
        wr(8'h00, 8'h82);
        rd(8'h00, d);
        `CHK(d, 8'h82)
        rd(8'h07, d);
        `CHK(d, 8'h00)
    endtask
    task automatic t_ext;
        op(OP_LD, 16'h2345, 5, 3, RG_EXT);
        `CHK(rd_data, 8'h1f)
        wr(8'h00, 8'h80);
        op(OP_ST, 16'hffff, 3, 1, RG_EXT);
        `CHK(ext_addr, 16'hffff)
        `CHK(ext_data_out, 8'h3c)
    endtask
    task automatic t_irq;
        @(posedge core_clk) irq_req <= 1'b1;
        op(OP_SEI, 16'h0000, 2, 0, RG_EXT);
        `CHK(irq_ack, 1'b0)
        @(posedge core_clk) begin
            op_valid <= 1'b1;
            op_code <= OP_ALU;
            op_cycles <= 3'h1;
        end
        @(posedge core_clk) op_valid <= 1'b0;
        @(negedge core_clk) `CHK(irq_ack, 1'b1)
        @(negedge core_clk) `CHK(sp_push3, 1'b1)
        n = 1;
        do begin
            @(negedge core_clk);
            n++;
        end while (op_ready !== 1'b1 && n < 40);
        `CHK(n, 9)
        `CHK(gie, 1'b0)
        `CHK(program_counter, 17'h0_000a)
        @(posedge core_clk) irq_req <= 1'b0;
        op(OP_RETURN_FROM_IRQ_INSTR, 16'h0000, 5, 1, RG_EXT);
        `CHK(gie, 1'b1)
        `CHK(program_counter, 17'h0_000b)
    endtask
    // Sleep, then wake-up: four start-up cycles, entry lengthened by five, vector jump
    task automatic t_sleep;
        @(posedge core_clk) begin
            op_valid <= 1'b1;
            op_code <= OP_SLEEP;
        end
        @(posedge core_clk) op_valid <= 1'b0;
        @(posedge core_clk) irq_req <= 1'b1;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (op_ready !== 1'b1 && n < 40);
        `CHK(n, 20)
        `CHK(program_counter, 17'h0_000a)
    endtask
    // Bus write enables with a request pending; the shadowed instruction disables again
    task automatic t_cli;
        wr(8'h01, 8'h80);
        @(negedge core_clk) `CHK(irq_ack, 1'b0)
        op(OP_CLI, 16'h0000, 2, 0, RG_EXT);
        `CHK(irq_ack, 1'b0)
        `CHK(gie, 1'b0)
        @(posedge core_clk) irq_req <= 1'b0;
    endtask
    // Pointer Y: store its high byte, pre-decrement, displacement, read back, external stack
    task automatic t_ptr;
        op(OP_ST, 16'h001d, 2, 0, RG_REGF);
        @(posedge core_clk) begin
            op_ptr <= PTR_Y;
            op_mode <= AM_PREDEC;
        end
        op(OP_LD, 16'h0000, 3, 1, RG_EXT);
        `CHK(ext_addr, 16'hc2ff)
        @(posedge core_clk) begin
            op_mode <= AM_DISP;
            op_disp <= 6'h3f;
        end
        op(OP_LD, 16'h0000, 3, 1, RG_EXT);
        `CHK(ext_addr, 16'hc33e)
        @(posedge core_clk) begin
            op_ptr <= PTR_DIRECT;
            op_mode <= AM_PLAIN;
            sp_addr <= 16'h8000;
        end
        op(OP_LD, 16'h001c, 2, 0, RG_REGF);
        `CHK(rd_data, 8'hff)
        op(OP_CALL, 16'h0000, 5, 0, RG_REGF);
    endtask
    // Main sequence after a two-cycle reset
    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        #1 `CHK(ext_read_strobe_pin_n, 1'b1)
        `CHK(program_counter, 17'h0_0000)
        t_decode;
        t_regs;
        t_ext;
        t_irq;
        t_sleep;
        t_cli;
        t_ptr;
        conclude;
    end
    // Watchdog: the tests need under two hundred cycles
    initial begin
        #8000;
        n_fail++;
        conclude;
    end
endmodule
